// >>> verilog/pmc_pkg.sv
package pmc_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_TX_GAP = 8'he0;
  localparam logic [7:0] IDX_LOOP = 8'he3;
  localparam logic [7:0] IDX_CRC = 8'he4;
  localparam logic [7:0] IDX_RX_GAP = 8'he5;
  localparam logic [7:0] IDX_MAX_LEN = 8'he6;
  localparam logic [7:0] IDX_MIN_LEN = 8'he7;
  localparam logic [7:0] IDX_LO_FRM = 8'he8;
  localparam logic [7:0] IDX_HI_FRM = 8'he9;
  localparam logic [7:0] IDX_LO_HW = 8'hea;
  localparam logic [7:0] IDX_HI_HW = 8'heb;
  localparam logic [7:0] IDX_TX_HW = 8'hec;
  localparam logic [7:0] IDX_GAP_ERR_CNT = 8'hde;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hed;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hee;

  // Field widths
  localparam int TX_GAP_W = 8;
  localparam int RX_GAP_W = 6;
  localparam int LEN_W = 16;
  localparam int FRM_W = 9;
  localparam int HW_W = 14;
  localparam int EVT_W = 3;

  // Reset values
  localparam logic [7:0] TX_GAP_RST = 8'h0b;
  localparam logic [5:0] RX_GAP_RST = 6'h0a;
  localparam logic [15:0] MAX_LEN_RST = 16'h0618;
  localparam logic [15:0] MIN_LEN_RST = 16'h0040;

  // Event bit positions in status and mask
  localparam int EVT_GAP = 0;
  localparam int EVT_CRC = 1;
  localparam int EVT_LEN = 2;

  // Timing: one MII nibble is four bit times
  localparam int CLK_NS = 40;
  localparam int NIBBLE_NS = 400;
  localparam int NIBBLE_CYC = NIBBLE_NS / CLK_NS;
  localparam int BITS_PER_NIBBLE = 4;

  typedef struct packed {
    logic [3:0] d;
    logic en;
  } pmc_mii_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pmc_apb_req_t;

  typedef struct packed {
    logic lo_frm_in;
    logic lo_frm_out;
    logic hi_frm_in;
    logic hi_frm_out;
    logic lo_hw_in;
    logic lo_hw_out;
    logic hi_hw_in;
    logic hi_hw_out;
    logic tx_hw_in;
    logic tx_hw_out;
  } pmc_fifo_evt_t;

endpackage : pmc_pkg

// >>> verilog/pmc_port_mac.sv
`timescale 1ns/10ps

// Function
// - The transmit side flags on tx_gap_busy an idle gap of (gap setting + 1) x 8 bit times after each frame; setting is 8 bits, reset 11.
// - With the loopback bit at 1 transmit traffic is returned on the MII receive side; at 0 it runs normally; reset 0.
// - Received frame CRC is checked only while the CRC check bit is set; it resets to 1.
// - The gap before each received frame must exceed the 6-bit receive gap setting x 8 bit times; reset 10.
// - A frame whose preceding gap is too short is dropped and the receive gap error is raised.
// - A 16-bit writable maximum receive frame length in bytes resets to 0x618.
// - A 16-bit writable minimum receive frame length in bytes resets to 0x40.
// - A 9-bit read-only count of frames in the low priority receive FIFO resets to zero.
// - A 9-bit read-only count of frames in the high priority receive FIFO resets to zero.
// - A 14-bit read-only level gives the valid half words in the low priority receive FIFO.
// - A 14-bit read-only level gives the valid half words in the high priority receive FIFO.
// - A 14-bit read-only level gives the half words waiting in the transmit FIFO toward the other port.
// - A 32-bit read-only counter of frames received with gap errors resets to zero.
module pmc_port_mac #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmc_pkg::pmc_mii_t mac_tx,
  output pmc_pkg::pmc_mii_t phy_tx,
  input wire pmc_pkg::pmc_mii_t phy_rx,
  output pmc_pkg::pmc_mii_t mac_rx,
  output logic tx_gap_busy,
  input wire logic rx_crc_bad,
  output logic rx_crc_check_on,
  output logic mac_loopback_on,
  output logic rx_gap_error_flag,
  input wire pmc_pkg::pmc_fifo_evt_t fifo_evt,
  output logic irq
);

  typedef struct packed {
    logic [7:0] tx_gap;
    logic loop;
    logic crc_on;
    logic [5:0] rx_gap;
    logic [15:0] max_len;
    logic [15:0] min_len;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [31:0] gap_err_cnt;
    logic [8:0] lo_frm;
    logic [8:0] hi_frm;
    logic [13:0] lo_hw;
    logic [13:0] hi_hw;
    logic [13:0] tx_hw;
    logic [3:0] div;
    logic tx_en_prev;
    logic [9:0] tx_gap_cnt;
    logic rx_dv_prev;
    logic [7:0] idle_nib;
    logic drop;
    logic [16:0] rx_nib;
    logic [31:0] rdata;
    logic slverr;
    pmc_pkg::pmc_mii_t phy_tx;
    pmc_pkg::pmc_mii_t mac_rx;
  } pmc_state_t;

  pmc_state_t st_q;
  pmc_state_t st_d;

  // Up/down count with saturation at zero and at the given top
  function automatic logic [13:0] cnt_step(input logic [13:0] c, input logic [13:0] top,
                                           input logic inc, input logic dec);
    logic [13:0] r;
    r = c;
    if (inc && !dec && c != top) begin
      r = c + 14'h0001;
    end else if (dec && !inc && c != 14'h0000) begin
      r = c - 14'h0001;
    end
    return r;
  endfunction : cnt_step

  typedef enum {
    SEL_NONE,
    SEL_TX_GAP,
    SEL_LOOP,
    SEL_CRC,
    SEL_RX_GAP,
    SEL_MAX_LEN,
    SEL_MIN_LEN,
    SEL_LO_FRM,
    SEL_HI_FRM,
    SEL_LO_HW,
    SEL_HI_HW,
    SEL_TX_HW,
    SEL_GAP_ERR,
    SEL_IRQ_STAT,
    SEL_IRQ_MASK
  } pmc_reg_sel_t;

  // Register index to register select, shared by the write and read paths
  function automatic pmc_reg_sel_t reg_decode(input logic [7:0] i);
    pmc_reg_sel_t s;
    s = SEL_NONE;
    if (i == pmc_pkg::IDX_TX_GAP) begin
      s = SEL_TX_GAP;
    end else if (i == pmc_pkg::IDX_LOOP) begin
      s = SEL_LOOP;
    end else if (i == pmc_pkg::IDX_CRC) begin
      s = SEL_CRC;
    end else if (i == pmc_pkg::IDX_RX_GAP) begin
      s = SEL_RX_GAP;
    end else if (i == pmc_pkg::IDX_MAX_LEN) begin
      s = SEL_MAX_LEN;
    end else if (i == pmc_pkg::IDX_MIN_LEN) begin
      s = SEL_MIN_LEN;
    end else if (i == pmc_pkg::IDX_LO_FRM) begin
      s = SEL_LO_FRM;
    end else if (i == pmc_pkg::IDX_HI_FRM) begin
      s = SEL_HI_FRM;
    end else if (i == pmc_pkg::IDX_LO_HW) begin
      s = SEL_LO_HW;
    end else if (i == pmc_pkg::IDX_HI_HW) begin
      s = SEL_HI_HW;
    end else if (i == pmc_pkg::IDX_TX_HW) begin
      s = SEL_TX_HW;
    end else if (i == pmc_pkg::IDX_GAP_ERR_CNT) begin
      s = SEL_GAP_ERR;
    end else if (i == pmc_pkg::IDX_IRQ_STAT) begin
      s = SEL_IRQ_STAT;
    end else if (i == pmc_pkg::IDX_IRQ_MASK) begin
      s = SEL_IRQ_MASK;
    end
    return s;
  endfunction : reg_decode

  localparam logic [3:0] DIV_LAST = 4'(pmc_pkg::NIBBLE_CYC - 1);
  localparam logic [13:0] FRM_TOP = 14'((1 << pmc_pkg::FRM_W) - 1);
  localparam logic [13:0] HW_TOP = 14'((1 << pmc_pkg::HW_W) - 1);
  localparam logic [9:0] GAP_NIB_PER_UNIT = 10'(8 / pmc_pkg::BITS_PER_NIBBLE);

  logic tick;
  logic [7:0] idx;
  logic aligned;
  logic setup;
  logic wr;
  pmc_pkg::pmc_mii_t rx_src;
  logic rx_start;
  logic rx_end;
  logic gap_short;
  logic [15:0] rx_bytes;
  logic [2:0] evt;
  pmc_reg_sel_t sel;

  assign tick = (st_q.div == DIV_LAST);
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && aligned;
  assign sel = aligned ? reg_decode(idx) : SEL_NONE;

  always_comb begin
    st_d = st_q;
    evt = 3'h0;

    st_d.div = tick ? 4'h0 : st_q.div + 4'h1;

    // Loopback turns the MAC transmit stream around toward its own receiver
    rx_src = st_q.loop ? mac_tx : phy_rx;
    st_d.phy_tx.d = st_q.loop ? 4'h0 : mac_tx.d;
    st_d.phy_tx.en = st_q.loop ? 1'b0 : mac_tx.en;

    // Transmit gap: counted in nibbles after the end of every frame
    st_d.tx_en_prev = mac_tx.en;
    if (st_q.tx_en_prev && !mac_tx.en) begin
      st_d.tx_gap_cnt = ({2'h0, st_q.tx_gap} + 10'h001) * GAP_NIB_PER_UNIT;
    end else if (tick && st_q.tx_gap_cnt != 10'h000) begin
      st_d.tx_gap_cnt = st_q.tx_gap_cnt - 10'h001;
    end

    // Receive gap check on the first cycle of each frame
    st_d.rx_dv_prev = rx_src.en;
    rx_start = rx_src.en && !st_q.rx_dv_prev;
    rx_end = !rx_src.en && st_q.rx_dv_prev;
    gap_short = rx_start && (st_q.idle_nib <= {1'b0, st_q.rx_gap, 1'b0});
    if (rx_src.en) begin
      st_d.idle_nib = 8'h00;
    end else if (tick && st_q.idle_nib != 8'hff) begin
      st_d.idle_nib = st_q.idle_nib + 8'h01;
    end
    if (rx_start) begin
      st_d.drop = gap_short;
    end else if (!rx_src.en) begin
      st_d.drop = 1'b0;
    end
    st_d.mac_rx.d = rx_src.d;
    st_d.mac_rx.en = rx_src.en && !st_d.drop;
    if (gap_short) begin
      evt[pmc_pkg::EVT_GAP] = 1'b1;
      st_d.gap_err_cnt = st_q.gap_err_cnt + 32'h00000001;
    end

    // Frame length in bytes against the programmed limits
    if (rx_start) begin
      st_d.rx_nib = 17'h00000;
    end else if (rx_src.en && tick && st_q.rx_nib != 17'h1ffff) begin
      st_d.rx_nib = st_q.rx_nib + 17'h00001;
    end
    rx_bytes = st_q.rx_nib[16:1];
    if (rx_end && !st_q.drop &&
        (rx_bytes < st_q.min_len || rx_bytes > st_q.max_len)) begin
      evt[pmc_pkg::EVT_LEN] = 1'b1;
    end

    // CRC failures only count while checking is enabled
    if (rx_crc_bad && st_q.crc_on) begin
      evt[pmc_pkg::EVT_CRC] = 1'b1;
    end

    // FIFO occupancy tracking
    st_d.lo_frm = 9'(cnt_step({5'h00, st_q.lo_frm}, FRM_TOP, fifo_evt.lo_frm_in,
                              fifo_evt.lo_frm_out));
    st_d.hi_frm = 9'(cnt_step({5'h00, st_q.hi_frm}, FRM_TOP, fifo_evt.hi_frm_in,
                              fifo_evt.hi_frm_out));
    st_d.lo_hw = cnt_step(st_q.lo_hw, HW_TOP, fifo_evt.lo_hw_in,
                          fifo_evt.lo_hw_out);
    st_d.hi_hw = cnt_step(st_q.hi_hw, HW_TOP, fifo_evt.hi_hw_in,
                          fifo_evt.hi_hw_out);
    st_d.tx_hw = cnt_step(st_q.tx_hw, HW_TOP, fifo_evt.tx_hw_in,
                          fifo_evt.tx_hw_out);

    // Register writes in the access phase; reserved bits are dropped
    st_d.stat = st_q.stat | evt;
    if (wr) begin
      case (sel)
        SEL_TX_GAP: begin
          st_d.tx_gap = pwdata[7:0];
        end
        SEL_LOOP: begin
          st_d.loop = pwdata[0];
        end
        SEL_CRC: begin
          st_d.crc_on = pwdata[0];
        end
        SEL_RX_GAP: begin
          st_d.rx_gap = pwdata[5:0];
        end
        SEL_MAX_LEN: begin
          st_d.max_len = pwdata[15:0];
        end
        SEL_MIN_LEN: begin
          st_d.min_len = pwdata[15:0];
        end
        SEL_IRQ_STAT: begin
          // Set wins over a clear arriving in the same cycle
          st_d.stat = (st_q.stat & ~pwdata[2:0]) | evt;
        end
        SEL_IRQ_MASK: begin
          st_d.mask = pwdata[2:0];
        end
        default: begin
          // Read-only and unmapped words ignore writes
        end
      endcase
    end

    // Read data and error are captured in the setup phase
    if (setup) begin
      st_d.rdata = 32'h00000000;
      st_d.slverr = 1'b0;
      case (sel)
        SEL_TX_GAP: begin
          st_d.rdata = {24'h000000, st_q.tx_gap};
        end
        SEL_LOOP: begin
          st_d.rdata = {31'h00000000, st_q.loop};
        end
        SEL_CRC: begin
          st_d.rdata = {31'h00000000, st_q.crc_on};
        end
        SEL_RX_GAP: begin
          st_d.rdata = {26'h0000000, st_q.rx_gap};
        end
        SEL_MAX_LEN: begin
          st_d.rdata = {16'h0000, st_q.max_len};
        end
        SEL_MIN_LEN: begin
          st_d.rdata = {16'h0000, st_q.min_len};
        end
        SEL_LO_FRM: begin
          st_d.rdata = {23'h000000, st_q.lo_frm};
        end
        SEL_HI_FRM: begin
          st_d.rdata = {23'h000000, st_q.hi_frm};
        end
        SEL_LO_HW: begin
          st_d.rdata = {18'h00000, st_q.lo_hw};
        end
        SEL_HI_HW: begin
          st_d.rdata = {18'h00000, st_q.hi_hw};
        end
        SEL_TX_HW: begin
          st_d.rdata = {18'h00000, st_q.tx_hw};
        end
        SEL_GAP_ERR: begin
          st_d.rdata = st_q.gap_err_cnt;
        end
        SEL_IRQ_STAT: begin
          st_d.rdata = {29'h00000000, st_q.stat};
        end
        SEL_IRQ_MASK: begin
          st_d.rdata = {29'h00000000, st_q.mask};
        end
        default: begin
          // Unaligned or unmapped: error, data stays zero
          st_d.slverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.tx_gap <= pmc_pkg::TX_GAP_RST;
      st_q.crc_on <= 1'b1;
      st_q.rx_gap <= pmc_pkg::RX_GAP_RST;
      st_q.max_len <= pmc_pkg::MAX_LEN_RST;
      st_q.min_len <= pmc_pkg::MIN_LEN_RST;
      st_q.idle_nib <= 8'hff;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = st_q.slverr && psel && penable;
  assign phy_tx = st_q.phy_tx;
  assign mac_rx = st_q.mac_rx;
  assign tx_gap_busy = (st_q.tx_gap_cnt != 10'h000);
  assign rx_crc_check_on = st_q.crc_on;
  assign mac_loopback_on = st_q.loop;
  assign rx_gap_error_flag = st_q.stat[pmc_pkg::EVT_GAP];
  assign irq = |(st_q.stat & st_q.mask);

endmodule : pmc_port_mac

// >>> tb/pmc_port_mac_chk.sv
`timescale 1ns/10ps
module pmc_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire pmc_pkg::pmc_mii_t mac_tx,
  input wire pmc_pkg::pmc_mii_t phy_tx,
  input wire pmc_pkg::pmc_mii_t mac_rx,
  input wire logic tx_gap_busy,
  input wire logic rx_crc_check_on,
  input wire logic mac_loopback_on,
  input wire logic rx_gap_error_flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  logic wr;
  assign wr = psel && penable && pwrite;
  sequence s_lb;
    mac_loopback_on && $past(mac_loopback_on);
  endsequence
  sequence s_drop;
    $rose(rx_gap_error_flag);
  endsequence
  sequence s_hold;
    !mac_rx.en [*4];
  endsequence
  property p_norm;
    !mac_loopback_on && !$past(mac_loopback_on) |-> phy_tx == $past(mac_tx);
  endproperty
  a_norm: assert property (p_norm) else $error("phy_tx not one cycle behind");
  property p_lb;
    s_lb |-> phy_tx == '0;
  endproperty
  a_lb: assert property (p_lb) else $error("phy_tx active in loopback");
  property p_lbrx;
    s_lb ##0 mac_rx.en |-> mac_rx.d == $past(mac_tx.d);
  endproperty
  a_lbrx: assert property (p_lbrx) else $error("loopback data wrong");
  property p_lbw;
    $changed(mac_loopback_on) |-> $past(wr && paddr == 12'h38c)
      && mac_loopback_on == $past(pwdata[0]);
  endproperty
  a_lbw: assert property (p_lbw) else $error("loopback bit moved");
  property p_crc;
    $changed(rx_crc_check_on) |-> $past(wr && paddr == 12'h390)
      && rx_crc_check_on == $past(pwdata[0]);
  endproperty
  a_crc: assert property (p_crc) else $error("crc enable moved");
  property p_drop;
    s_drop |-> s_hold;
  endproperty
  a_drop: assert property (p_drop) else $error("short-gap frame passed");
  property p_sticky;
    $fell(rx_gap_error_flag) |-> $past(wr && paddr == 12'h3b4 && pwdata[0]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("gap error lost");
  property p_err;
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unaligned access accepted");
  property p_gap;
    $fell(mac_tx.en) |=> ##[0:1] tx_gap_busy [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("tx gap too short");
endmodule : pmc_chk
bind pmc_port_mac pmc_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

// >>> tb/pmc_phy.sv
`timescale 1ns/10ps
module pmc_phy (
  input wire logic clock,
  input wire pmc_pkg::pmc_mii_t phy_tx,
  output pmc_pkg::pmc_mii_t phy_rx
);
  logic act = 1'b0;
  logic [3:0] nib = 4'h0;
  pmc_pkg::pmc_mii_t rx_q = '0;
  assign phy_rx = rx_q;
  // Idle data toggles so stale nibbles never look valid
  always @(posedge clock) begin
    rx_q.en <= act;
    rx_q.d <= act ? nib : ~rx_q.d;
  end
  task automatic frame(input int n);
    for (int i = 0; i < n; i++) begin
      act <= 1'b1;
      nib <= 4'(i + 3);
      repeat (pmc_pkg::NIBBLE_CYC) @(posedge clock);
    end
    act <= 1'b0;
  endtask : frame
endmodule : pmc_phy

// >>> tb/tb_port_mac_config_and_fifo_status.sv
`timescale 1ns/10ps
module tb_port_mac_config_and_fifo_status;
  typedef struct packed {
    logic [11:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } pmc_row_t;
  logic clock = 0;
  logic reset_n = 0;
  logic psel = 0, penable = 0, pwrite = 0, rx_crc_bad = 0;
  logic pready, pslverr, err, tx_gap_busy, irq;
  logic rx_gap_error_flag, mac_loopback_on, rx_crc_check_on;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  pmc_pkg::pmc_mii_t mac_tx = '0, phy_tx, phy_rx, mac_rx;
  pmc_pkg::pmc_fifo_evt_t fifo_evt = '0;
  int num_errors = 0, checks_done = 0, n;
  pmc_row_t rows [15] = '{
    '{12'h380, 1'b0, 32'h0, 32'h0b, 1'b0},
    '{12'h38c, 1'b0, 32'h0, 32'h0, 1'b0},
    '{12'h390, 1'b0, 32'h0, 32'h1, 1'b0},
    '{12'h394, 1'b0, 32'h0, 32'h0a, 1'b0},
    '{12'h398, 1'b0, 32'h0, 32'h618, 1'b0},
    '{12'h39c, 1'b0, 32'h0, 32'h40, 1'b0},
    '{12'h378, 1'b0, 32'h0, 32'h0, 1'b0},
    '{12'h380, 1'b1, 32'hffffff05, 32'h05, 1'b0},
    '{12'h394, 1'b1, 32'hffffffc4, 32'h04, 1'b0},
    '{12'h398, 1'b1, 32'hffff1234, 32'h1234, 1'b0},
    '{12'h390, 1'b1, 32'hfffffffe, 32'h0, 1'b0},
    '{12'h390, 1'b1, 32'h1, 32'h1, 1'b0},
    '{12'h3a8, 1'b1, 32'hffff, 32'h0, 1'b0},
    '{12'h3bc, 1'b1, 32'h5, 32'h0, 1'b1},
    '{12'h382, 1'b1, 32'h5, 32'h0, 1'b1}
  };
  always #20 clock = ~clock;
  pmc_port_mac i_dut (.*);
  pmc_phy i_phy (.*);
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task lvl(input logic [31:0] x);
    for (int i = 0; i < 5; i++) begin
      apb(12'h3a0 + 12'(4 * i), 0, 0);
      chk(rd, x);
    end
  endtask : lvl
  task stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1;
    @(negedge clock);
    chk(rx_crc_check_on, 1);
    chk(mac_loopback_on, 0);
    foreach (rows[i]) begin
      if (rows[i].w) apb(rows[i].a, 1, rows[i].d);
      apb(rows[i].a, 0, 0);
      chk(rd, rows[i].x);
      chk(err, rows[i].e);
    end
    lvl(0);
    fifo_evt <= 10'h2aa;
    repeat (3) @(posedge clock);
    fifo_evt <= 10'h3ff;
    @(posedge clock);
    fifo_evt <= 10'h155;
    @(posedge clock);
    fifo_evt <= '0;
    lvl(2);
    rx_crc_bad <= 1;
    @(posedge clock);
    rx_crc_bad <= 0;
    apb(12'h3b4, 0, 0);
    chk(rd & 32'h2, 32'h2);
    apb(12'h3b4, 1, 32'h7);
    i_phy.frame(4);
    repeat (150) @(posedge clock);
    i_phy.frame(4);
    repeat (20) @(posedge clock);
    chk(rx_gap_error_flag, 0);
    i_phy.frame(4);
    repeat (20) @(posedge clock);
    chk(rx_gap_error_flag, 1);
    chk(irq, 0);
    apb(12'h378, 0, 0);
    chk(rd, 1);
    apb(12'h3b8, 1, 32'h1);
    @(negedge clock);
    chk(irq, 1);
    apb(12'h3b4, 1, 32'h7);
    @(negedge clock);
    chk(irq, 0);
    apb(12'h38c, 1, 32'h1);
    // Idle long enough that the looped frame passes the gap check
    repeat (100) @(posedge clock);
    mac_tx <= '{d: 4'h5, en: 1'b1};
    repeat (20) @(posedge clock);
    mac_tx <= '0;
    n = 0;
    repeat (300) begin
      @(posedge clock);
      n += tx_gap_busy;
    end
    chk(n >= 100 && n <= 140, 1);
    chk(rx_gap_error_flag, 0);
    apb(12'h38c, 1, 32'h0);
    stop_test();
  end
endmodule : tb_port_mac_config_and_fifo_status
